// ===== core/erb_ram_block.v
// Dual-port embedded RAM block with AXI4-Lite configuration registers
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "erb_defines.vh"

// Operation
// - Hold 4,096 data bits, 4,608 with parity
// - Nine word shapes up to 36 bits wide
// - Two ports read or write independently
// - Byte lane masks select stored bytes
// - Clock enable halts both data ports; register bus and preload keep running
// - Input registers have no asynchronous clear
// - Output clear acts at once, no edge
// - Reset by power-up, output clear, device-wide clear
// - Same port read-during-write shows new data
// - Other port read-during-write shows old data
// - Contents preloadable before normal operation
// - Ports may differ in width, addresses scaled
// - Lane masks default disabled; masked bytes kept
// - Address hold recirculates each port's address
// - Inputs registered; output pipelined or flow-through
// - Enabled lane shows new byte during write
module erb_ram_block (
  input wire clk,
  input wire rst_b,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire blockEnable,
  input wire [11:0] addrA,
  input wire [35:0] dataInA,
  input wire wrEnA,
  input wire [3:0] byteEnA,
  input wire addrHoldA,
  input wire outClearA,
  output wire [35:0] dataOutA,
  input wire [11:0] addrB,
  input wire [35:0] dataInB,
  input wire wrEnB,
  input wire [3:0] byteEnB,
  input wire addrHoldB,
  input wire outClearB,
  output wire [35:0] dataOutB
);

  // 512 nine-bit bytes give 4,608 bits
  reg [8:0] mem [0:`ERB_BYTES-1];

  reg [12:0] ctrlQ;
  reg [8:0] initAddrQ;
  reg [15:0] wrCountQ;
  reg [11:0] addrAQ;
  reg [11:0] addrBQ;
  reg [35:0] dataAQ;
  reg [35:0] dataBQ;
  reg weAQ;
  reg weBQ;
  reg [3:0] beAQ;
  reg [3:0] beBQ;
  reg [35:0] outAQ;
  reg [35:0] outBQ;
  reg awHeldQ;
  reg wHeldQ;
  reg [7:0] awAddrQ;
  reg [31:0] wDataQ;
  reg [3:0] wStrbQ;

  wire [3:0] widthA = ctrlQ[`ERB_CTRL_WA_LSB +: 4];
  wire [3:0] widthB = ctrlQ[`ERB_CTRL_WB_LSB +: 4];
  wire pipeA = ctrlQ[`ERB_CTRL_PIPE_A];
  wire pipeB = ctrlQ[`ERB_CTRL_PIPE_B];
  wire [1:0] mode = ctrlQ[`ERB_CTRL_MODE_LSB +: 2];
  wire maskOn = ctrlQ[`ERB_CTRL_MASK_ON];
  wire singleMode = (mode == `ERB_MODE_SINGLE);
  wire trueMode = (mode == `ERB_MODE_TRUE);

  // Port B writes only in true dual-port; B is read-only in simple
  wire wrA = weAQ;
  wire wrB = weBQ & trueMode;

  wire [8:0] baseA;
  wire [8:0] baseB;
  wire [3:0] validA;
  wire [3:0] validB;
  wire [35:0] maskA;
  wire [35:0] maskB;
  wire [35:0] valA;
  wire [35:0] valB;
  wire [35:0] oldA;
  wire [35:0] oldB;
  wire [35:0] newA;
  wire [35:0] newB;
  wire [35:0] idxA;
  wire [35:0] idxB;
  wire [3:0] laneWrA;
  wire [3:0] laneWrB;
  wire [35:0] flowA;
  wire [35:0] flowB;
  wire badA;
  wire badB;
  wire initWrite;

  // Address scaling per port width, so widths may differ
  erb_port_map mapA (
    .widthCode(widthA),
    .addr(addrAQ),
    .wrData(dataAQ),
    .bytesIn(newA),
    .baseIdx(baseA),
    .laneValid(validA),
    .laneMask(maskA),
    .laneVal(valA),
    .rdData(flowA),
    .badWidth(badA)
  );

  erb_port_map mapB (
    .widthCode(widthB),
    .addr(addrBQ),
    .wrData(dataBQ),
    .bytesIn(newB),
    .baseIdx(baseB),
    .laneValid(validB),
    .laneMask(maskB),
    .laneVal(valB),
    .rdData(flowB),
    .badWidth(badB)
  );

  // Lane fetch and merge; each port sees only its own pending write
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gLane
      wire [31:0] sumA = baseA + g;
      wire [31:0] sumB = baseB + g;
      assign idxA[9*g +: 9] = sumA[8:0];
      assign idxB[9*g +: 9] = sumB[8:0];
      assign oldA[9*g +: 9] = mem[idxA[9*g +: 9]];
      assign oldB[9*g +: 9] = mem[idxB[9*g +: 9]];
      assign laneWrA[g] = wrA & beAQ[g] & validA[g];
      assign laneWrB[g] = wrB & beBQ[g] & validB[g];
      // Enabled lanes flow the new byte through; masked keep stored
      assign newA[9*g +: 9] = laneWrA[g] ?
        ((oldA[9*g +: 9] & ~maskA[9*g +: 9]) | valA[9*g +: 9]) : oldA[9*g +: 9];
      assign newB[9*g +: 9] = laneWrB[g] ?
        ((oldB[9*g +: 9] & ~maskB[9*g +: 9]) | valB[9*g +: 9]) : oldB[9*g +: 9];
    end
  endgenerate

  // Input registers: synchronous device-wide clear only
  always @(posedge clk) begin
    if (!rst_b) begin
      addrAQ <= 12'h000;
      addrBQ <= 12'h000;
      dataAQ <= 36'h0;
      dataBQ <= 36'h0;
      weAQ <= 1'b0;
      weBQ <= 1'b0;
      beAQ <= 4'hf;
      beBQ <= 4'hf;
    end else if (blockEnable) begin
      addrAQ <= addrHoldA ? addrAQ : addrA;
      addrBQ <= addrHoldB ? addrBQ : addrB;
      dataAQ <= dataInA;
      dataBQ <= dataInB;
      weAQ <= wrEnA;
      weBQ <= wrEnB;
      // With masks off every lane writes on write enable alone
      beAQ <= maskOn ? byteEnA : 4'hf;
      beBQ <= maskOn ? byteEnB : 4'hf;
    end
  end

  // Array write; no reset so clears never touch contents
  // Same byte written by both ports: port B wins unless A writes it from a higher lane
  integer k;
  always @(posedge clk) begin
    if (blockEnable) begin
      for (k = 0; k < 4; k = k + 1) begin
        if (laneWrA[k]) begin
          mem[idxA[9*k +: 9]] <= newA[9*k +: 9];
        end
        if (laneWrB[k]) begin
          mem[idxB[9*k +: 9]] <= newB[9*k +: 9];
        end
      end
    end
    // Preload path from the register bus
    if (initWrite) begin
      mem[initAddrQ] <= wDataQ[8:0];
    end
  end

  // Output registers: async clear, then device-wide clear
  always @(posedge clk or posedge outClearA) begin
    if (outClearA) begin
      outAQ <= 36'h0;
    end else if (!rst_b) begin
      outAQ <= 36'h0;
    end else if (blockEnable) begin
      outAQ <= flowA;
    end
  end

  always @(posedge clk or posedge outClearB) begin
    if (outClearB) begin
      outBQ <= 36'h0;
    end else if (!rst_b) begin
      outBQ <= 36'h0;
    end else if (blockEnable) begin
      outBQ <= singleMode ? 36'h0 : flowB;
    end
  end

  // Pipelined or flow-through output select
  assign dataOutA = pipeA ? outAQ : flowA;
  assign dataOutB = pipeB ? outBQ : (singleMode ? 36'h0 : flowB);

  // Committed port writes, counted for status; a cycle where both ports write counts two
  always @(posedge clk) begin
    if (!rst_b) begin
      wrCountQ <= 16'h0000;
    end else if (blockEnable) begin
      wrCountQ <= wrCountQ + {15'h0000, |laneWrA} + {15'h0000, |laneWrB};
    end
  end

  // Register decode shared by read and write paths
  function [3:0] regSel;
    input [7:0] a;
    begin
      case (a)
        `ERB_OFS_CTRL: regSel = 4'h1;
        `ERB_OFS_STATUS: regSel = 4'h2;
        `ERB_OFS_INIT_ADDR: regSel = 4'h4;
        `ERB_OFS_INIT_DATA: regSel = 4'h8;
        default: regSel = 4'h0;
      endcase
    end
  endfunction

  // Write channel: address and data taken in either order
  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake = s_axi_wvalid & s_axi_wready;
  wire wrGo = awHeldQ & wHeldQ & ~s_axi_bvalid;
  wire [3:0] wrSel = regSel(awAddrQ);
  assign initWrite = wrGo & wrSel[3] & wStrbQ[0];

  assign s_axi_awready = ~awHeldQ & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeldQ & ~s_axi_bvalid;

  always @(posedge clk) begin
    if (!rst_b) begin
      awHeldQ <= 1'b0;
      wHeldQ <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h0;
      wStrbQ <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ERB_RESP_OKAY;
    end else begin
      if (awTake) begin
        awHeldQ <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeldQ <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (wrGo) begin
        awHeldQ <= 1'b0;
        wHeldQ <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Status is read-only, so a write to it is refused too
        s_axi_bresp <= (wrSel[0] | wrSel[2] | wrSel[3]) ?
          `ERB_RESP_OKAY : `ERB_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control and preload address; byte strobes honoured per lane
  always @(posedge clk) begin
    if (!rst_b) begin
      ctrlQ <= `ERB_CTRL_RESET;
      initAddrQ <= `ERB_INIT_ADDR_RESET;
    end else if (wrGo) begin
      if (wrSel[0]) begin
        if (wStrbQ[0]) begin
          ctrlQ[7:0] <= wDataQ[7:0];
        end
        if (wStrbQ[1]) begin
          ctrlQ[12:8] <= wDataQ[12:8];
        end
      end
      if (wrSel[2] & wStrbQ[0]) begin
        initAddrQ[7:0] <= wDataQ[7:0];
      end
      if (wrSel[2] & wStrbQ[1]) begin
        initAddrQ[8] <= wDataQ[8];
      end
      // Preload steps through the array one byte per write
      if (initWrite) begin
        initAddrQ <= initAddrQ + 9'h001;
      end
    end
  end

  // Read channel: one-cycle answer, unmapped gives SLVERR
  wire [3:0] rdSel = regSel(s_axi_araddr);
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge clk) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `ERB_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= (|rdSel) ? `ERB_RESP_OKAY : `ERB_RESP_SLVERR;
      case (rdSel)
        4'h1: s_axi_rdata <= {19'h0, ctrlQ};
        4'h2: s_axi_rdata <= {15'h0, badA | badB, wrCountQ};
        4'h4: s_axi_rdata <= {23'h0, initAddrQ};
        default: s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== core/erb_defines.vh
// Constants shared by the embedded RAM block files
`ifndef ERB_DEFINES_VH
`define ERB_DEFINES_VH

// Storage shape: 512 nine-bit bytes, 4,608 bits with parity
`define ERB_BYTES 512
`define ERB_DATA_BITS 4096
`define ERB_TOTAL_BITS 4608

// Port width codes
`define ERB_W_X1 4'h0
`define ERB_W_X2 4'h1
`define ERB_W_X4 4'h2
`define ERB_W_X8 4'h3
`define ERB_W_X9 4'h4
`define ERB_W_X16 4'h5
`define ERB_W_X18 4'h6
`define ERB_W_X32 4'h7
`define ERB_W_X36 4'h8

// Port modes
`define ERB_MODE_SINGLE 2'h0
`define ERB_MODE_SIMPLE 2'h1
`define ERB_MODE_TRUE 2'h2

// Register byte offsets
`define ERB_OFS_CTRL 8'h00
`define ERB_OFS_STATUS 8'h04
`define ERB_OFS_INIT_ADDR 8'h08
`define ERB_OFS_INIT_DATA 8'h0c

// Control field positions
`define ERB_CTRL_WA_LSB 0
`define ERB_CTRL_WB_LSB 4
`define ERB_CTRL_PIPE_A 8
`define ERB_CTRL_PIPE_B 9
`define ERB_CTRL_MODE_LSB 10
`define ERB_CTRL_MASK_ON 12

// Status field positions
`define ERB_STAT_CFG_ERR 16

// Reset values
`define ERB_CTRL_RESET 13'h0b88
`define ERB_INIT_ADDR_RESET 9'h000

// Bus answers
`define ERB_RESP_OKAY 2'h0
`define ERB_RESP_SLVERR 2'h2

`endif

// ===== core/erb_port_map.v
// Maps one port's word address and width onto the nine-bit byte store
`timescale 1ns/100ps
`include "erb_defines.vh"

module erb_port_map (
  input wire [3:0] widthCode,
  input wire [11:0] addr,
  input wire [35:0] wrData,
  input wire [35:0] bytesIn,
  output reg [8:0] baseIdx,
  output reg [3:0] laneValid,
  output reg [35:0] laneMask,
  output reg [35:0] laneVal,
  output reg [35:0] rdData,
  output reg badWidth
);

  reg narrow;
  reg nine;
  reg [2:0] lanes;
  reg [3:0] off;
  reg [8:0] bitMask;
  integer i;

  // Width decode: narrow widths share one byte, wide ones span lanes
  always @* begin
    narrow = 1'b0;
    nine = 1'b0;
    lanes = 3'h1;
    off = 4'h0;
    bitMask = 9'h1ff;
    badWidth = 1'b0;
    baseIdx = addr[8:0];
    case (widthCode)
      `ERB_W_X1: begin
        narrow = 1'b1;
        bitMask = 9'h001;
        baseIdx = addr[11:3];
        off = {1'b0, addr[2:0]};
      end
      `ERB_W_X2: begin
        narrow = 1'b1;
        bitMask = 9'h003;
        baseIdx = addr[10:2];
        off = {1'b0, addr[1:0], 1'b0};
      end
      `ERB_W_X4: begin
        narrow = 1'b1;
        bitMask = 9'h00f;
        baseIdx = addr[9:1];
        off = {1'b0, addr[0], 2'h0};
      end
      `ERB_W_X8: baseIdx = addr[8:0];
      `ERB_W_X9: begin
        nine = 1'b1;
        baseIdx = addr[8:0];
      end
      `ERB_W_X16: begin
        lanes = 3'h2;
        baseIdx = {addr[7:0], 1'b0};
      end
      `ERB_W_X18: begin
        nine = 1'b1;
        lanes = 3'h2;
        baseIdx = {addr[7:0], 1'b0};
      end
      `ERB_W_X32: begin
        lanes = 3'h4;
        baseIdx = {addr[6:0], 2'h0};
      end
      `ERB_W_X36: begin
        nine = 1'b1;
        lanes = 3'h4;
        baseIdx = {addr[6:0], 2'h0};
      end
      default: begin
        // Unknown code runs as x36 and is flagged
        nine = 1'b1;
        lanes = 3'h4;
        baseIdx = {addr[6:0], 2'h0};
        badWidth = 1'b1;
      end
    endcase
  end

  // Per-lane write mask and value; ninth bit stored as plain data
  always @* begin
    laneValid = 4'h0;
    laneMask = 36'h0;
    laneVal = 36'h0;
    rdData = 36'h0;
    for (i = 0; i < 4; i = i + 1) begin
      if (i < lanes) begin
        laneValid[i] = 1'b1;
        if (narrow) begin
          laneMask[9*i +: 9] = bitMask << off;
          laneVal[9*i +: 9] = (wrData[8:0] & bitMask) << off;
          rdData[8:0] = (bytesIn[8:0] >> off) & bitMask;
        end else if (nine) begin
          laneMask[9*i +: 9] = 9'h1ff;
          laneVal[9*i +: 9] = wrData[9*i +: 9];
          rdData[9*i +: 9] = bytesIn[9*i +: 9];
        end else begin
          // Byte widths leave the parity bit untouched
          laneMask[9*i +: 9] = 9'h0ff;
          laneVal[9*i +: 9] = {1'b0, wrData[8*i +: 8]};
          rdData[8*i +: 8] = bytesIn[9*i +: 8];
        end
      end
    end
  end

endmodule

// ===== test/erb_ram_block_assertions.sv
// Port-level assertions for the embedded RAM block
`timescale 1ns/100ps
module erb_ram_block_assertions (
  input wire clk,
  input wire rst_b,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire blockEnable,
  input wire wrEnA,
  input wire wrEnB,
  input wire [35:0] dataInA,
  input wire outClearA,
  input wire outClearB,
  input wire [35:0] dataOutA,
  input wire [35:0] dataOutB
);
  // Reset shape is x36 pipelined; data checks stop once CTRL is written
  logic cfgDef_q;
  always @(posedge clk) begin
    if (!rst_b)
      cfgDef_q <= 1'b1;
    else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h00)
      cfgDef_q <= 1'b0;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Steps of a port A write followed by an enabled edge, and of a joint AW and W handshake
  sequence sWrA;
    blockEnable && wrEnA && !wrEnB && !outClearA && cfgDef_q;
  endsequence
  sequence sNextOn;
    blockEnable && !outClearA;
  endsequence
  sequence sAwW;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  AST_NEW_DATA_A: assert property (sWrA ##1 sNextOn |=>
    outClearA || dataOutA == $past(dataInA, 2))
    else $error("port A output missed its own write");
  AST_CLEAR_A: assert property (outClearA && cfgDef_q |-> dataOutA == 36'h0)
    else $error("port A output not cleared");
  AST_CLEAR_B: assert property (outClearB && cfgDef_q |-> dataOutB == 36'h0)
    else $error("port B output not cleared");
  AST_STALL: assert property (!blockEnable && cfgDef_q && !outClearA && !outClearB |=>
    outClearA || outClearB || ($stable(dataOutA) && $stable(dataOutB)))
    else $error("output moved while block disabled");
  // Both halves held one edge, then the answer is raised on the next
  AST_WR_ANSWER: assert property (sAwW |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer stuck");
endmodule

bind erb_ram_block erb_ram_block_assertions u_erbChk (.clk, .rst_b, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .blockEnable, .wrEnA, .wrEnB,
  .dataInA, .outClearA, .outClearB, .dataOutA, .dataOutB);

// ===== test/erb_fabric_model.sv
// Fabric-side user logic that drives both data ports of the RAM block
`timescale 1ns/100ps
module erb_fabric_model (
  input wire clk,
  output logic [11:0] addrA,
  output logic [35:0] dataInA,
  output logic wrEnA,
  output logic [3:0] byteEnA,
  output logic [11:0] addrB,
  output logic [35:0] dataInB,
  output logic wrEnB,
  output logic [3:0] byteEnB
);
  // Quiet ports before the first access
  initial begin
    {addrA, dataInA, wrEnA, byteEnA} = '0;
    {addrB, dataInB, wrEnB, byteEnB} = '0;
  end

  // Lane parity is made out here; the block only stores the ninth bit
  function automatic logic [35:0] withParity(input logic [31:0] d);
    return {^d[31:24], d[31:24], ^d[23:16], d[23:16], ^d[15:8], d[15:8], ^d[7:0], d[7:0]};
  endfunction

  // One access, held over the sampling edge, then data inverted so stale
  // values never pass for a write plain RAM use, no pointer logic
  task automatic op(input int wa, input int aa, input logic [35:0] da, input int ba,
                    input int wb, input int ab, input logic [35:0] db, input int bb);
    @(posedge clk);
    wrEnA <= 1'(wa);
    addrA <= 12'(aa);
    dataInA <= da;
    byteEnA <= 4'(ba);
    wrEnB <= 1'(wb);
    addrB <= 12'(ab);
    dataInB <= db;
    byteEnB <= 4'(bb);
    @(posedge clk);
    wrEnA <= 1'b0;
    wrEnB <= 1'b0;
    dataInA <= ~da;
    dataInB <= ~db;
    @(posedge clk);
    #1;
  endtask
endmodule

// ===== test/test_erb_ram_block.sv
// Self-checking bench for the embedded RAM block
`timescale 1ns/100ps
`include "erb_defines.vh"
module test_erb_ram_block;
  logic clk = 1'b0, rst_b = 1'b0, blockEnable = 1'b1;
  logic addrHoldA = 1'b0, addrHoldB = 1'b0, outClearA = 1'b0, outClearB = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wrEnA, wrEnB;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [11:0] addrA, addrB;
  wire [3:0] byteEnA, byteEnB;
  wire [35:0] dataInA, dataInB, dataOutA, dataOutB;
  int num_errors = 0, checked = 0;
  logic [1:0] resp;
  logic [31:0] rdVal;
  logic [35:0] pre, d0, d1, lm, ex;

  // 250 MHz clock
  always #2 clk = ~clk;

  erb_ram_block DUT (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .blockEnable, .addrA, .dataInA, .wrEnA, .byteEnA,
    .addrHoldA, .outClearA, .dataOutA, .addrB, .dataInB, .wrEnB, .byteEnB, .addrHoldB,
    .outClearB, .dataOutB);
  erb_fabric_model fab (.clk, .addrA, .dataInA, .wrEnA, .byteEnA, .addrB, .dataInB, .wrEnB,
    .byteEnB);

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bail();
    num_errors++;
    $display("CHECK FAILED bus answer expected in time seen none");
    end_of_test();
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    logic ra, rw, rb;
    n = 0;
    rb = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!rb) begin
      @(negedge clk);
      ra = s_axi_awready;
      rw = s_axi_wready;
      rb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (ra) s_axi_awvalid <= 1'b0;
      if (rw) s_axi_wvalid <= 1'b0;
      n++;
      if (n > 40) bail();
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axiRd(input logic [7:0] a);
    int n;
    logic ra, rv;
    n = 0;
    rv = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rv) begin
      @(negedge clk);
      ra = s_axi_arready;
      rv = s_axi_rvalid;
      rdVal = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ra) s_axi_arvalid <= 1'b0;
      n++;
      if (n > 40) bail();
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic chkRegs();
    axiRd(`ERB_OFS_CTRL);
    chk("ctrl reset", 36'(rdVal), 36'(`ERB_CTRL_RESET));
    axiWr(`ERB_OFS_STATUS, 32'h1, 4'hf);
    chk("status write", 36'(resp), 36'(`ERB_RESP_SLVERR));
    axiWr(8'h40, 32'h1, 4'hf);
    chk("unmapped write", 36'(resp), 36'(`ERB_RESP_SLVERR));
  endtask

  task automatic chkPreload();
    axiWr(`ERB_OFS_INIT_ADDR, 32'h4, 4'hf);
    for (int i = 0; i < 4; i++) begin
      pre[9 * i +: 9] = 9'h0a5 + 9'(9'h053 * i);
      axiWr(`ERB_OFS_INIT_DATA, 32'(pre[9 * i +: 9]), 4'h1);
    end
    axiRd(`ERB_OFS_INIT_ADDR);
    chk("init address step", 36'(rdVal), 36'h8);
    fab.op(0, 1, 36'h0, 0, 0, 1, 36'h0, 0);
    chk("preload A", dataOutA, pre);
    chk("preload B", dataOutB, pre);
  endtask

  // Lane enables low while masks are off still write
  task automatic chkRdw();
    d0 = fab.withParity(32'h1234abcd);
    d1 = fab.withParity(32'hfedc0042);
    fab.op(1, 2, d0, 0, 0, 0, 36'h0, 0);
    fab.op(1, 2, d1, 0, 0, 2, 36'h0, 0);
    chk("same port new", dataOutA, d1);
    chk("other port old", dataOutB, d0);
    fab.op(1, 3, d0, 15, 1, 4, d1, 15);
    fab.op(0, 4, 36'h0, 0, 0, 3, 36'h0, 0);
    chk("dual write A", dataOutA, d1);
    chk("dual write B", dataOutB, d0);
  endtask

  task automatic chkStall();
    @(posedge clk);
    blockEnable <= 1'b0;
    fab.op(1, 4, d0, 15, 1, 4, d0, 15);
    chk("stalled out", dataOutA, d1);
    @(posedge clk);
    blockEnable <= 1'b1;
    fab.op(0, 4, 36'h0, 0, 0, 4, 36'h0, 0);
    chk("stalled write", dataOutA, d1);
    fab.op(0, 1, 36'h0, 0, 0, 1, 36'h0, 0);
    @(posedge clk);
    addrHoldA <= 1'b1;
    fab.op(0, 2, 36'h0, 0, 0, 2, 36'h0, 0);
    chk("held address", dataOutA, pre);
    chk("free address", dataOutB, d1);
    @(posedge clk);
    addrHoldA <= 1'b0;
    addrHoldB <= 1'b1;
    fab.op(0, 1, 36'h0, 0, 0, 1, 36'h0, 0);
    chk("released address A", dataOutA, pre);
    chk("held address B", dataOutB, d1);
    @(posedge clk);
    addrHoldB <= 1'b0;
  endtask

  task automatic chkClear();
    fab.op(0, 1, 36'h0, 0, 0, 1, 36'h0, 0);
    @(posedge clk);
    outClearA <= 1'b1;
    outClearB <= 1'b1;
    #1;
    chk("clear A", dataOutA, 36'h0);
    chk("clear B", dataOutB, 36'h0);
    @(posedge clk);
    outClearA <= 1'b0;
    outClearB <= 1'b0;
    @(posedge clk);
    #1;
    chk("after clear", dataOutA, pre);
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk("reset out", dataOutA, 36'h0);
    fab.op(0, 1, 36'h0, 0, 0, 1, 36'h0, 0);
    chk("after reset", dataOutA, pre);
  endtask

  task automatic chkMask();
    axiWr(`ERB_OFS_CTRL, 32'h1988, 4'h3);
    d0 = fab.withParity(32'h5a5a5a5a);
    lm = 36'h007fc01ff;
    ex = (d0 & lm) | (d1 & ~lm);
    fab.op(1, 2, d0, 5, 0, 2, 36'h0, 0);
    chk("masked write out", dataOutA, ex);
    fab.op(0, 2, 36'h0, 0, 0, 2, 36'h0, 0);
    chk("masked kept", dataOutA, ex);
  endtask

  // Every shape at its last word, then x8 against x36 on one store
  task automatic chkWidths();
    int wb[9] = '{1, 2, 4, 8, 9, 16, 18, 32, 36};
    int dp[9] = '{4096, 2048, 1024, 512, 512, 256, 256, 128, 128};
    for (int c = 0; c < 9; c++) begin
      axiWr(`ERB_OFS_CTRL, 32'h0980 | c, 4'h3);
      lm = (36'h1 << wb[c]) - 36'h1;
      fab.op(1, dp[c] - 1, 36'h9a5c3e71b, 15, 0, 0, 36'h0, 0);
      chk("shape write", dataOutA & lm, 36'h9a5c3e71b & lm);
      fab.op(0, dp[c] - 1, 36'h0, 0, 0, 0, 36'h0, 0);
      chk("shape read", dataOutA & lm, 36'h9a5c3e71b & lm);
    end
    axiWr(`ERB_OFS_CTRL, 32'h0983, 4'h3);
    fab.op(1, 9, 36'h05a, 15, 0, 2, 36'h0, 0);
    fab.op(0, 9, 36'h0, 0, 0, 2, 36'h0, 0);
    chk("mixed width", 36'(dataOutB[16:9]), 36'h05a);
  endtask

  // Write cycles counted since the mid-run reset, then a bad shape code
  task automatic chkStatus();
    axiRd(`ERB_OFS_STATUS);
    chk("write count", 36'(rdVal[15:0]), 36'h00b);
    chk("width ok", 36'(rdVal[16]), 36'h0);
    axiWr(`ERB_OFS_CTRL, 32'h0989, 4'h3);
    axiRd(`ERB_OFS_STATUS);
    chk("width bad", 36'(rdVal[16]), 36'h1);
  endtask

  // Port B writes dropped in simple mode, B output quiet in single mode
  task automatic chkModes();
    axiWr(`ERB_OFS_CTRL, 32'h0588, 4'h3);
    fab.op(1, 5, d0, 15, 1, 5, d1, 15);
    fab.op(0, 5, 36'h0, 0, 0, 5, 36'h0, 0);
    chk("simple A", dataOutA, d0);
    chk("simple B", dataOutB, d0);
    axiWr(`ERB_OFS_CTRL, 32'h0188, 4'h3);
    fab.op(0, 5, 36'h0, 0, 0, 5, 36'h0, 0);
    chk("single A", dataOutA, d0);
    chk("single B", dataOutB, 36'h0);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    chkRegs();
    chkPreload();
    chkRdw();
    chkStall();
    chkClear();
    chkMask();
    chkWidths();
    chkStatus();
    chkModes();
    end_of_test();
  end
endmodule
